// ===== pkg/agc_consts.svh
`ifndef AGC_CONSTS_SVH
`define AGC_CONSTS_SVH

// Register indices; byte address is four times the index.
`define IDX_TARGET      18'h0df17
`define IDX_PRIO_CS     18'h0df18
`define IDX_DYN         18'h0df19
`define IDX_STATUS      18'h0df40
`define IDX_MANUAL      18'h0df41

// Reset values.
`define RST_TARGET      3'h3
`define RST_PRIO        1'h1
`define RST_REL         2'h0
`define RST_ABS         4'h0
`define RST_HYST        2'h2
`define RST_WAIT        2'h1
`define RST_FRZ         2'h0
`define RST_FLEN        2'h1

// Field positions.
`define POS_PRIO        6
`define POS_REL         4
`define POS_ABS         0
`define POS_HYST        6
`define POS_WAIT        4
`define POS_FRZ         2
`define POS_FLEN        0
`define POS_SECOND_RF_AMPLIFIER_MAN    4
`define POS_DIGITAL_VARIABLE_GAIN_STAGE_MAN    8
`define POS_RSSI_STAT   8

// Carrier sense, gain and averaging figures.
`define ABS_OFF         4'h8
`define REL_DB_1        8'h06
`define REL_DB_2        8'h0a
`define REL_DB_3        8'h0e
`define GAIN_MAX        3'h7
`define GAIN_FULL       5'h15
`define GAIN_STEP_DB    5'h03
`define WAIT_UNIT       7'h08
`define AVG_MIN         7'h08
`define AVG_BASE_SHIFT  3'h3

// Amplitude target in dB per code.
`define TGT_DB_0        8'h18
`define TGT_DB_1        8'h1b
`define TGT_DB_2        8'h1e
`define TGT_DB_3        8'h21
`define TGT_DB_4        8'h24
`define TGT_DB_5        8'h26
`define TGT_DB_6        8'h28
`define TGT_DB_7        8'h2a

`endif

// ===== pkg/agc_pkg.sv
package agc_pkg;

    typedef enum logic [2:0] {
        S_WAIT = 3'b001,
        S_ACC  = 3'b010,
        S_ADJ  = 3'b100
    } agc_state_type;

    typedef enum logic [1:0] {
        FRZ_NONE   = 2'h0,
        FRZ_SYNC   = 2'h1,
        FRZ_ANALOG = 2'h2,
        FRZ_ALL    = 2'h3
    } gain_hold_policy_type;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [19:0] paddr;
        logic [31:0] pwdata;
        logic [3:0]  pstrb;
    } apb_req_type;

    typedef struct packed {
        logic        pready;
        logic [31:0] prdata;
        logic        pslverr;
    } apb_rsp_type;

    typedef struct packed {
        logic [2:0] lna1;
        logic [2:0] second_rf_amplifier;
        logic [2:0] digital_variable_gain_stage;
    } gains_type;

endpackage : agc_pkg

// ===== src/rx_gain_control_carrier_sense.sv
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ps
`include "agc_consts.svh"
// Notes on behaviour
// - Priority bit 1 reduces first amplifier first; 0 empties second amplifier first.
// - Relative threshold code selects off, 6, 10 or 14 dB signal increase.
// - Absolute threshold is signed, 1 dB steps, relative to amplitude target.
// - Absolute code 1000 disables the absolute criterion altogether.
// - Compared strength equals filter amplitude while no gain was taken away.
// - Hysteresis code sets dead zone on the deviation; 00 symmetric and small.
// - After a gain change, discard 8, 16, 24 or 32 samples.
// - Hold code 00 adjusts gain whenever the loop asks.
// - Sync hold code freezes all gain while i_sync_found is high.
// - Analog hold code freezes amplifiers, digital gain still moves.
// - Full hold freezes all gain; software may load gains by hand.
// - Averaging code selects 8, 16, 32 or 64 samples.
// - Target code maps to 24..42 dB; resets to 33 dB.
module rx_gain_control_carrier_sense (
    // Clock and reset
    input  wire logic                 i_clk,
    input  wire logic                 i_rst_b,
    // APB slave
    input  wire agc_pkg::apb_req_type i_apb,
    output agc_pkg::apb_rsp_type      o_apb,
    // Receive datapath
    input  wire logic                 i_amp_valid,
    input  wire logic [7:0]           i_amp,
    input  wire logic                 i_sync_found,
    // Gain and carrier sense
    output agc_pkg::gains_type        o_gains,
    output logic                      o_carrier_sense
);
    import agc_pkg::*;

    typedef struct packed {
        logic [2:0]           target;
        logic                 prio;
        logic [1:0]           rel;
        logic [3:0]           abs;
        logic [1:0]           hyst;
        logic [1:0]           waitc;
        gain_hold_policy_type frz;
        logic [1:0]           flen;
        gains_type            gains;
        agc_state_type        fsm;
        logic [6:0]           cnt;
        logic [13:0]          sum;
        logic [8:0]           rssi;
        logic [8:0]           ref_lvl;
        logic                 rel_hit;
        logic                 cs;
        apb_rsp_type          rsp;
    } state_type;

    localparam state_type ST_RST = '{
        target: `RST_TARGET, prio: `RST_PRIO, rel: `RST_REL, abs: `RST_ABS,
        hyst: `RST_HYST, waitc: `RST_WAIT, frz: gain_hold_policy_type'(`RST_FRZ),
        flen: `RST_FLEN,
        gains: '{lna1: `GAIN_MAX, second_rf_amplifier: `GAIN_MAX, digital_variable_gain_stage: `GAIN_MAX},
        fsm: S_WAIT, cnt: 7'h00, sum: 14'h0000, rssi: 9'h000, ref_lvl: 9'h1ff,
        rel_hit: 1'b0, cs: 1'b0, rsp: '{pready: 1'b0, prdata: 32'h0, pslverr: 1'b0}
    };

    function automatic logic [7:0] target_db(input logic [2:0] c);
        case (c)
            3'h0:    target_db = `TGT_DB_0;
            3'h1:    target_db = `TGT_DB_1;
            3'h2:    target_db = `TGT_DB_2;
            3'h3:    target_db = `TGT_DB_3;
            3'h4:    target_db = `TGT_DB_4;
            3'h5:    target_db = `TGT_DB_5;
            3'h6:    target_db = `TGT_DB_6;
            default: target_db = `TGT_DB_7;
        endcase
    endfunction : target_db

    function automatic logic [7:0] rel_db(input logic [1:0] c);
        case (c)
            2'h1:    rel_db = `REL_DB_1;
            2'h2:    rel_db = `REL_DB_2;
            2'h3:    rel_db = `REL_DB_3;
            default: rel_db = 8'h00;
        endcase
    endfunction : rel_db

    function automatic logic [6:0] wait_len(input logic [1:0] c);
        wait_len = 7'({c, 3'h0}) + `WAIT_UNIT;
    endfunction : wait_len

    function automatic logic [6:0] avg_len(input logic [1:0] c);
        avg_len = `AVG_MIN << c;
    endfunction : avg_len

    // Deviation above which gain drops; the rise threshold widens faster,
    // which gives the asymmetric dead zone of the higher codes.
    function automatic logic [3:0] dec_thr(input logic [1:0] h);
        dec_thr = 4'({2'h0, h}) + 4'h1;
    endfunction : dec_thr

    function automatic logic [3:0] inc_thr(input logic [1:0] h);
        case (h)
            2'h0:    inc_thr = 4'h1;
            2'h1:    inc_thr = 4'h3;
            2'h2:    inc_thr = 4'h5;
            default: inc_thr = 4'h8;
        endcase
    endfunction : inc_thr

    state_type          st_reg;
    state_type          st_next;
    logic [7:0]         avg;
    logic [7:0]         tgt;
    logic [4:0]         steps;
    logic [8:0]         rssi_now;
    logic signed [9:0]  dev;
    logic signed [10:0] abs_thr;
    logic               dec;
    logic               inc;
    logic               frz_dig;
    logic               frz_an;
    logic               abs_ok;
    logic               rel_rise;
    logic               acc;
    logic               done;
    logic               mapped;
    logic [17:0]        idx;
    logic [31:0]        rdata;

    always_comb begin
        st_next  = st_reg;
        avg      = 8'(st_reg.sum >> ({1'b0, st_reg.flen} + `AVG_BASE_SHIFT));
        tgt      = target_db(st_reg.target);
        steps    = `GAIN_FULL - {2'h0, st_reg.gains.lna1} - {2'h0, st_reg.gains.second_rf_amplifier}
                   - {2'h0, st_reg.gains.digital_variable_gain_stage};
        // With no gain taken away the strength is the bare amplitude.
        rssi_now = {1'b0, avg} + {3'h0, 6'(steps * `GAIN_STEP_DB)};
        dev      = $signed({2'h0, avg}) - $signed({2'h0, tgt});
        dec      = dev > $signed({6'h0, dec_thr(st_reg.hyst)});
        inc      = dev < -$signed({6'h0, inc_thr(st_reg.hyst)});
        frz_dig  = (st_reg.frz == FRZ_ALL) || (st_reg.frz == FRZ_SYNC && i_sync_found);
        frz_an   = frz_dig || (st_reg.frz == FRZ_ANALOG);
        abs_thr  = $signed({3'h0, tgt}) + 11'($signed(st_reg.abs));
        abs_ok   = (st_reg.abs != `ABS_OFF) && ($signed({2'h0, rssi_now}) >= abs_thr);
        // No reference exists after reset; the top level keeps the first result from
        // counting as a rise, and the wider sum keeps that level from wrapping.
        rel_rise = {1'b0, rssi_now} >= {1'b0, st_reg.ref_lvl} + {2'h0, rel_db(st_reg.rel)};
        case (st_reg.fsm)
            S_WAIT: begin
                if (i_amp_valid) begin
                    st_next.cnt = st_reg.cnt + 7'h01;
                    if (st_reg.cnt == wait_len(st_reg.waitc) - 7'h01) begin
                        st_next.cnt = 7'h00;
                        st_next.sum = 14'h0000;
                        st_next.fsm = S_ACC;
                    end
                end
            end
            S_ACC: begin
                if (i_amp_valid) begin
                    st_next.sum = st_reg.sum + {6'h00, i_amp};
                    st_next.cnt = st_reg.cnt + 7'h01;
                    if (st_reg.cnt == avg_len(st_reg.flen) - 7'h01) begin
                        st_next.fsm = S_ADJ;
                    end
                end
            end
            S_ADJ: begin
                st_next.rssi = rssi_now;
                if (st_reg.rel == 2'h0) begin
                    st_next.rel_hit = 1'b0;
                    st_next.ref_lvl = rssi_now;
                end else if (st_reg.rel_hit != rel_rise) begin
                    st_next.rel_hit = rel_rise;
                end
                if (!rel_rise) begin
                    st_next.ref_lvl = rssi_now;
                end
                st_next.cs = abs_ok || (st_reg.rel != 2'h0 && rel_rise);
                if (dec && !frz_dig) begin
                    if (!frz_an && st_reg.prio && st_reg.gains.lna1 != 3'h0) begin
                        st_next.gains.lna1 = st_reg.gains.lna1 - 3'h1;
                    end else if (!frz_an && st_reg.gains.second_rf_amplifier != 3'h0) begin
                        st_next.gains.second_rf_amplifier = st_reg.gains.second_rf_amplifier - 3'h1;
                    end else if (!frz_an && st_reg.gains.lna1 != 3'h0) begin
                        st_next.gains.lna1 = st_reg.gains.lna1 - 3'h1;
                    end else if (st_reg.gains.digital_variable_gain_stage != 3'h0) begin
                        st_next.gains.digital_variable_gain_stage = st_reg.gains.digital_variable_gain_stage - 3'h1;
                    end
                end else if (inc && !frz_dig) begin
                    if (st_reg.gains.digital_variable_gain_stage != `GAIN_MAX) begin
                        st_next.gains.digital_variable_gain_stage = st_reg.gains.digital_variable_gain_stage + 3'h1;
                    end else if (!frz_an && !st_reg.prio && st_reg.gains.lna1 != `GAIN_MAX) begin
                        st_next.gains.lna1 = st_reg.gains.lna1 + 3'h1;
                    end else if (!frz_an && st_reg.gains.second_rf_amplifier != `GAIN_MAX) begin
                        st_next.gains.second_rf_amplifier = st_reg.gains.second_rf_amplifier + 3'h1;
                    end else if (!frz_an && st_reg.gains.lna1 != `GAIN_MAX) begin
                        st_next.gains.lna1 = st_reg.gains.lna1 + 3'h1;
                    end
                end
                // Settling samples are skipped only when the gain really moved.
                st_next.cnt = 7'h00;
                st_next.sum = 14'h0000;
                st_next.fsm = (st_next.gains != st_reg.gains) ? S_WAIT : S_ACC;
            end
            default: begin
                st_next.fsm = S_WAIT;
                st_next.cnt = 7'h00;
            end
        endcase

        // APB: one wait state, so every access phase lasts two cycles.
        acc    = i_apb.psel && i_apb.penable;
        done   = acc && st_reg.rsp.pready;
        idx    = i_apb.paddr[19:2];
        mapped = (i_apb.paddr[1:0] == 2'h0) && (idx == `IDX_TARGET || idx == `IDX_PRIO_CS ||
                 idx == `IDX_DYN || idx == `IDX_STATUS || idx == `IDX_MANUAL);
        rdata  = 32'h0;
        case (idx)
            `IDX_TARGET:  rdata[2:0] = st_reg.target;
            `IDX_PRIO_CS: rdata[7:0] = {1'b0, st_reg.prio, st_reg.rel, st_reg.abs};
            `IDX_DYN:     rdata[7:0] = {st_reg.hyst, st_reg.waitc, st_reg.frz, st_reg.flen};
            `IDX_STATUS:  rdata[16:0] = {st_reg.rssi, 6'h00, st_reg.rel_hit, st_reg.cs};
            `IDX_MANUAL:  rdata[10:0] = {st_reg.gains.digital_variable_gain_stage, 1'b0, st_reg.gains.second_rf_amplifier, 1'b0,
                                         st_reg.gains.lna1};
            default:      rdata = 32'h0;
        endcase
        st_next.rsp.pready  = acc && !st_reg.rsp.pready;
        st_next.rsp.pslverr = acc && !st_reg.rsp.pready && !mapped;
        st_next.rsp.prdata  = (acc && !st_reg.rsp.pready && !i_apb.pwrite) ? rdata : 32'h0;
        if (done && i_apb.pwrite && mapped && i_apb.pstrb[0]) begin
            case (idx)
                `IDX_TARGET:  st_next.target = i_apb.pwdata[2:0];
                `IDX_PRIO_CS: begin
                    st_next.prio = i_apb.pwdata[`POS_PRIO];
                    st_next.rel  = i_apb.pwdata[`POS_REL +: 2];
                    st_next.abs  = i_apb.pwdata[`POS_ABS +: 4];
                end
                `IDX_DYN: begin
                    st_next.hyst  = i_apb.pwdata[`POS_HYST +: 2];
                    st_next.waitc = i_apb.pwdata[`POS_WAIT +: 2];
                    st_next.frz   = gain_hold_policy_type'(i_apb.pwdata[`POS_FRZ +: 2]);
                    st_next.flen  = i_apb.pwdata[`POS_FLEN +: 2];
                end
                `IDX_MANUAL: begin
                    if (st_reg.frz == FRZ_ALL) begin
                        st_next.gains.lna1 = i_apb.pwdata[2:0];
                        st_next.gains.second_rf_amplifier = i_apb.pwdata[`POS_SECOND_RF_AMPLIFIER_MAN +: 3];
                    end
                end
                default: st_next.target = st_reg.target;
            endcase
        end
        if (done && i_apb.pwrite && idx == `IDX_MANUAL && i_apb.pstrb[1]
            && st_reg.frz == FRZ_ALL) begin
            st_next.gains.digital_variable_gain_stage = i_apb.pwdata[`POS_DIGITAL_VARIABLE_GAIN_STAGE_MAN +: 3];
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            st_reg <= ST_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    assign o_apb           = st_reg.rsp;
    assign o_gains         = st_reg.gains;
    assign o_carrier_sense = st_reg.cs;

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_b);

    logic man_wr;
    assign man_wr = done && i_apb.pwrite && idx == `IDX_MANUAL;

    property p_prio_first;
        st_reg.fsm == S_ADJ && dec && !frz_an && st_reg.prio && st_reg.gains.lna1 != 3'h0
        |=> st_reg.gains.lna1 == $past(st_reg.gains.lna1) - 3'h1 && $stable(st_reg.gains.second_rf_amplifier);
    endproperty
    a_prio_first: assert property (p_prio_first) else $error("first amplifier not cut first");

    property p_prio_second;
        st_reg.fsm == S_ADJ && dec && !frz_an && !st_reg.prio && st_reg.gains.second_rf_amplifier != 3'h0
        |=> st_reg.gains.second_rf_amplifier == $past(st_reg.gains.second_rf_amplifier) - 3'h1 && $stable(st_reg.gains.lna1);
    endproperty
    a_prio_second: assert property (p_prio_second) else $error("second amplifier not cut first");

    property p_both_off;
        st_reg.fsm == S_ADJ && st_reg.abs == `ABS_OFF && st_reg.rel == 2'h0 |=> !o_carrier_sense;
    endproperty
    a_both_off: assert property (p_both_off) else $error("carrier sense with criteria off");

    property p_full_gain_rssi;
        st_reg.fsm == S_ADJ && steps == 5'h00 |=> st_reg.rssi == {1'b0, $past(avg)};
    endproperty
    a_full_gain_rssi: assert property (p_full_gain_rssi) else $error("strength not amplitude");

    property p_wait_done;
        st_reg.fsm == S_WAIT && i_amp_valid && st_reg.cnt == wait_len(st_reg.waitc) - 7'h01
        |=> st_reg.fsm == S_ACC ##1 st_reg.fsm == S_ACC;
    endproperty
    a_wait_done: assert property (p_wait_done) else $error("settling wait length wrong");

    property p_no_hold;
        st_reg.fsm == S_ADJ && st_reg.frz == FRZ_NONE && dec && steps != 5'h15
        |=> st_reg.gains != $past(st_reg.gains) && st_reg.fsm == S_WAIT;
    endproperty
    a_no_hold: assert property (p_no_hold) else $error("gain not reduced");

    property p_sync_hold;
        st_reg.frz == FRZ_SYNC && i_sync_found |=> $stable(st_reg.gains);
    endproperty
    a_sync_hold: assert property (p_sync_hold) else $error("gain moved after sync");

    property p_analog_hold;
        st_reg.frz == FRZ_ANALOG |=> $stable(st_reg.gains.lna1) && $stable(st_reg.gains.second_rf_amplifier);
    endproperty
    a_analog_hold: assert property (p_analog_hold) else $error("analog gain moved");

    property p_full_hold;
        st_reg.frz == FRZ_ALL && !man_wr |=> $stable(st_reg.gains);
    endproperty
    a_full_hold: assert property (p_full_hold) else $error("gain moved in full hold");

    property p_avg_len;
        st_reg.fsm == S_ACC && i_amp_valid && st_reg.cnt == avg_len(st_reg.flen) - 7'h01
        |=> st_reg.fsm == S_ADJ ##1 st_reg.fsm != S_ADJ;
    endproperty
    a_avg_len: assert property (p_avg_len) else $error("averaging length wrong");

    property p_top_bit;
        acc && !st_reg.rsp.pready && !i_apb.pwrite && idx == `IDX_PRIO_CS
        |=> o_apb.pready && o_apb.prdata[7] == 1'b0;
    endproperty
    a_top_bit: assert property (p_top_bit) else $error("unused bit reads one");

    c_gain_cut: cover property (st_reg.fsm == S_ADJ && dec ##1 st_reg.fsm == S_WAIT);
    c_cs_rise: cover property (!o_carrier_sense ##1 o_carrier_sense);
    c_manual: cover property (man_wr && st_reg.frz == FRZ_ALL);
endmodule : rx_gain_control_carrier_sense

// ===== tb/tb_top.sv
`timescale 1ns/1ps
`include "agc_consts.svh"
module tb_top;
    import agc_pkg::*;
    logic        clk;
    logic        rst_b;
    apb_req_type req;
    apb_rsp_type rsp;
    logic        amp_valid;
    logic [7:0]  amp;
    logic        sync_found;
    gains_type   gains;
    logic        cs;
    int          failures;
    int          compares;
    logic [7:0]  tgt_db [8];
    logic [7:0]  rel_db [4];
    logic [7:0]  b;
    logic [31:0] rd;
    logic        err;
    gains_type   full;

    rx_gain_control_carrier_sense i_dut (
        .i_clk           (clk),
        .i_rst_b         (rst_b),
        .i_apb           (req),
        .o_apb           (rsp),
        .i_amp_valid     (amp_valid),
        .i_amp           (amp),
        .i_sync_found    (sync_found),
        .o_gains         (gains),
        .o_carrier_sense (cs)
    );

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp

    task automatic tally_and_finish();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : tally_and_finish

    task automatic rst();
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
    endtask : rst

    // The request is held until the rising edge at which pready is seen high.
    task automatic apb(input logic wr, input logic [17:0] idx, input logic [31:0] wd);
        @(posedge clk);
        req.psel    <= 1'b1;
        req.penable <= 1'b0;
        req.pwrite  <= wr;
        req.paddr   <= {idx, 2'b00};
        req.pwdata  <= wd;
        req.pstrb   <= 4'hf;
        @(posedge clk);
        req.penable <= 1'b1;
        do @(posedge clk); while (rsp.pready !== 1'b1);
        rd          = rsp.prdata;
        err         = rsp.pslverr;
        req.psel    <= 1'b0;
        req.penable <= 1'b0;
    endtask : apb

    // Fresh reset, configuration, two phases of samples, then check outputs and status.
    task automatic run(input logic [7:0] ctl, input logic [7:0] dyn, input logic [2:0] tgt,
                       input logic sync, input logic [7:0] a, input int na,
                       input logic [7:0] bb, input int nb, input logic ecs,
                       input gains_type eg, input logic [8:0] estr);
        rst();
        apb(1'b1, `IDX_TARGET, {29'h0, tgt});
        apb(1'b1, `IDX_PRIO_CS, {24'h0, ctl});
        apb(1'b1, `IDX_DYN, {24'h0, dyn});
        sync_found <= sync;
        for (int i = 0; i < na + nb; i++) begin
            @(posedge clk);
            amp_valid <= 1'b1;
            amp       <= (i < na) ? a : bb;
        end
        @(posedge clk);
        amp_valid <= 1'b0;
        repeat (4) @(negedge clk);
        cmp("gains", {23'h0, eg}, {23'h0, gains});
        cmp("carrier_sense", {31'h0, ecs}, {31'h0, cs});
        apb(1'b0, `IDX_STATUS, 32'h0);
        cmp("status_cs", {31'h0, ecs}, {31'h0, rd[0]});
        if (ctl[3:0] == `ABS_OFF) begin
            cmp("status_rel", {31'h0, ecs}, {31'h0, rd[1]});
        end
        cmp("strength", {23'h0, estr}, {23'h0, rd[16:8]});
    endtask : run

    initial begin
        #5_000_000;
        failures++;
        tally_and_finish();
    end

    initial begin
        failures   = 0;
        compares   = 0;
        rst_b      = 1'b0;
        req        = '0;
        amp_valid  = 1'b0;
        amp        = 8'h00;
        sync_found = 1'b0;
        full       = {3'h7, 3'h7, 3'h7};
        tgt_db     = '{8'h18, 8'h1b, 8'h1e, 8'h21, 8'h24, 8'h26, 8'h28, 8'h2a};
        rel_db     = '{8'h00, 8'h06, 8'h0a, 8'h0e};
        rst();
        @(negedge clk);
        cmp("reset_gains", {23'h0, full}, {23'h0, gains});
        apb(1'b0, `IDX_TARGET, 32'h0);
        cmp("target_reset", 32'h3, rd);
        apb(1'b0, `IDX_PRIO_CS, 32'h0);
        cmp("prio_cs_reset", 32'h40, rd);
        apb(1'b0, `IDX_DYN, 32'h0);
        cmp("dyn_reset", 32'h91, rd);
        apb(1'b1, `IDX_PRIO_CS, 32'hff);
        apb(1'b0, `IDX_PRIO_CS, 32'h0);
        cmp("prio_cs_top_bit", 32'h7f, rd);
        apb(1'b1, `IDX_DYN, 32'h5a);
        apb(1'b0, `IDX_DYN, 32'h0);
        cmp("dyn_rw", 32'h5a, rd);
        apb(1'b0, 18'h0df20, 32'h0);
        cmp("unmapped_err", 32'h1, {31'h0, err});
        cmp("unmapped_data", 32'h0, rd);
        apb(1'b1, `IDX_MANUAL, 32'h152);
        @(negedge clk);
        cmp("manual_ignored", {23'h0, full}, {23'h0, gains});
        apb(1'b1, `IDX_DYN, 32'h0c);
        apb(1'b1, `IDX_MANUAL, 32'h152);
        @(negedge clk);
        cmp("manual_gains", {23'h0, 3'h2, 3'h5, 3'h1}, {23'h0, gains});
        apb(1'b0, `IDX_MANUAL, 32'h0);
        cmp("manual_read", 32'h152, rd);
        for (int t = 0; t < 8; t++) begin
            b = tgt_db[t] - 8'h01;
            run(8'h40, 8'h00, 3'(t), 1'b0, tgt_db[t], 16, 8'h0, 0, 1'b1, full, {1'b0, tgt_db[t]});
            run(8'h40, 8'h00, 3'(t), 1'b0, b, 16, 8'h0, 0, 1'b0, full, {1'b0, b});
        end
        run(8'h41, 8'h00, 3'h3, 1'b0, 8'h21, 16, 8'h0, 0, 1'b0, full, 9'h021);
        run(8'h4f, 8'h00, 3'h3, 1'b0, 8'h21, 16, 8'h0, 0, 1'b1, full, 9'h021);
        run(8'h48, 8'h00, 3'h3, 1'b0, 8'h21, 16, 8'h0, 0, 1'b0, full, 9'h021);
        run(8'h47, 8'h00, 3'h3, 1'b0, 8'h28, 16, 8'h0, 0, 1'b1, {3'h6, 3'h7, 3'h7},
            9'h028);
        run(8'h49, 8'h00, 3'h3, 1'b0, 8'h1a, 16, 8'h0, 0, 1'b1, full, 9'h01a);
        run(8'h49, 8'h00, 3'h3, 1'b0, 8'h19, 16, 8'h0, 0, 1'b0, full, 9'h019);
        // The first second-phase sample falls in the adjust cycle and is dropped.
        for (int r = 1; r < 4; r++) begin
            b = 8'h1e + rel_db[r];
            run({2'b00, 2'(r), 4'h8}, 8'hc0, 3'h7, 1'b0, 8'h1e, 16, b, 9, 1'b1, full, {1'b0, b});
            b = b - 8'h01;
            run({2'b00, 2'(r), 4'h8}, 8'hc0, 3'h7, 1'b0, 8'h1e, 16, b, 9, 1'b0, full, {1'b0, b});
        end
        // Strength is taken with the gains that stood while the samples were averaged.
        run(8'h40, 8'h00, 3'h3, 1'b0, 8'h3c, 16, 8'h0, 0, 1'b1, {3'h6, 3'h7, 3'h7}, 9'h03c);
        run(8'h00, 8'h00, 3'h3, 1'b0, 8'h3c, 16, 8'h0, 0, 1'b1, {3'h7, 3'h6, 3'h7}, 9'h03c);
        run(8'h40, 8'h0c, 3'h3, 1'b0, 8'h3c, 16, 8'h0, 0, 1'b1, full, 9'h03c);
        run(8'h40, 8'h04, 3'h3, 1'b1, 8'h3c, 16, 8'h0, 0, 1'b1, full, 9'h03c);
        run(8'h40, 8'h04, 3'h3, 1'b0, 8'h3c, 16, 8'h0, 0, 1'b1, {3'h6, 3'h7, 3'h7}, 9'h03c);
        run(8'h40, 8'h08, 3'h3, 1'b0, 8'h3c, 16, 8'h0, 0, 1'b1, {3'h7, 3'h7, 3'h6}, 9'h03c);
        run(8'h40, 8'h00, 3'h3, 1'b0, 8'h23, 16, 8'h0, 0, 1'b1, {3'h6, 3'h7, 3'h7}, 9'h023);
        run(8'h40, 8'h40, 3'h3, 1'b0, 8'h23, 16, 8'h0, 0, 1'b1, full, 9'h023);
        run(8'h40, 8'h80, 3'h3, 1'b0, 8'h24, 16, 8'h0, 0, 1'b1, full, 9'h024);
        run(8'h40, 8'hc0, 3'h3, 1'b0, 8'h25, 16, 8'h0, 0, 1'b1, full, 9'h025);
        run(8'h40, 8'h10, 3'h3, 1'b0, 8'h21, 16, 8'h0, 0, 1'b0, full, 9'h000);
        run(8'h40, 8'h10, 3'h3, 1'b0, 8'h21, 24, 8'h0, 0, 1'b1, full, 9'h021);
        run(8'h40, 8'h01, 3'h3, 1'b0, 8'h21, 16, 8'h0, 0, 1'b0, full, 9'h000);
        run(8'h40, 8'h01, 3'h3, 1'b0, 8'h21, 24, 8'h0, 0, 1'b1, full, 9'h021);
        run(8'h40, 8'h33, 3'h3, 1'b0, 8'h21, 95, 8'h0, 0, 1'b0, full, 9'h000);
        run(8'h40, 8'h33, 3'h3, 1'b0, 8'h21, 96, 8'h0, 0, 1'b1, full, 9'h021);
        tally_and_finish();
    end
endmodule : tb_top
